/* hdl/slip_compensator.sv */
// Computes the transmit bitslip that complements the receive aligner slip.
// Assumes rx_slip and resync are synchronous to hclk.
`timescale 1ns/100ps
module slip_compensator #(
  parameter int unsigned width = 5
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             master_mode,
  input  wire logic             override_en,
  input  wire logic [width-1:0] manual_slip,
  input  wire logic [width-1:0] rx_slip,
  input  wire logic             resync,
  output logic [width-1:0]      tx_slip,
  output logic [width-1:0]      held_rx_slip
);
  logic [width-1:0] target_q;
  logic             calibrated_q;
  logic [width-1:0] auto_slip;

  // Total of rx and tx slip is held at the target modulo 2 to the power width.
  assign auto_slip = width'(target_q - held_rx_slip);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_rx_slip <= '0;
      target_q     <= '0;
      calibrated_q <= 1'b0;
      tx_slip      <= '0;
    end else begin
      if (resync) begin
        held_rx_slip <= rx_slip;
        if (!calibrated_q) begin
          target_q     <= rx_slip;
          calibrated_q <= 1'b1;
        end
      end
      if (master_mode)
        tx_slip <= '0;
      else if (override_en)
        tx_slip <= manual_slip;
      else
        tx_slip <= auto_slip;
    end
  end
endmodule : slip_compensator

/* hdl/tx_delay_meter.sv */
// Accumulates the phase-and-occupancy delay of the Tx elastic buffer.
// Assumes the sampled transmit clock and occupancy come from the core clock.
`timescale 1ns/100ps
module tx_delay_meter (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [15:0] divider,
  input  wire logic [3:0]  occupancy,
  input  wire logic        tx_clk_level,
  output logic [31:0]      delay_count,
  output logic             delay_valid
);
  logic [15:0] window_q;
  logic [31:0] acc_q;
  logic        window_end;

  assign window_end = (window_q >= divider);

  // Each divider step adds the current word count; a low tx clock level
  // adds one more count of phase lag, so the total over a window of divider
  // samples divided by the divider gives the delay in words.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      window_q    <= 16'h0000;
      acc_q       <= 32'h0000_0000;
      delay_count <= 32'h0000_0000;
      delay_valid <= 1'b0;
    end else if (window_end) begin
      window_q    <= 16'h0001;
      acc_q       <= {28'h0000000, occupancy}
                     + {31'h00000000, ~tx_clk_level};
      delay_count <= acc_q;
      delay_valid <= 1'b1;
    end else begin
      window_q <= window_q + 16'h0001;
      acc_q    <= acc_q + {28'h0000000, occupancy}
                  + {31'h00000000, ~tx_clk_level};
    end
  end
endmodule : tx_delay_meter

/* hdl/tx_latency_pkg.sv */
// Constants, types and register map for the transmit-path latency block.
// Assumes a 32-bit AHB-Lite register bus; nothing here is clocked.
package tx_latency_pkg;

  // Register byte offsets.
  localparam logic [7:0] slip_reg_offset    = 8'h00;
  localparam logic [7:0] divider_reg_offset = 8'h04;
  localparam logic [7:0] delay_reg_offset   = 8'h08;
  localparam logic [7:0] fixed_reg_offset   = 8'h0c;
  localparam logic [7:0] config_reg_offset  = 8'h10;

  // Field positions in the slip control register.
  localparam int rx_slip_lsb    = 0;
  localparam int tx_slip_lsb    = 8;
  localparam int override_bit   = 16;
  localparam int slip_width     = 5;

  // Reset values.
  localparam logic [15:0] divider_reset = 16'h0001;
  localparam logic        override_reset = 1'b0;

  // Fixed latencies in thousandths of a core cycle, so none is rounded.
  localparam logic [15:0] lat_low_all           = 16'h0ea6; // 3.75.
  localparam logic [15:0] lat_low_autorate_on   = 16'h0ea6; // 3.75.
  localparam logic [15:0] lat_low_autorate_off  = 16'h0dac; // 3.5.
  localparam logic [15:0] lat_high_autorate_on  = 16'h157c; // 5.5.
  localparam logic [15:0] lat_high_autorate_off = 16'h1388; // 5.0.
  localparam logic [15:0] lat_high_big          = 16'h1770; // 6.
  localparam logic [15:0] lat_high_small        = 16'h1194; // 4.5.
  localparam logic [15:0] lat_top_rate          = 16'h1770; // 6.
  localparam logic [15:0] xcvr_small_fam        = 16'h0d16; // 3.35.
  localparam logic [15:0] xcvr_big_low          = 16'h1ce8; // 7.4.
  localparam logic [15:0] xcvr_big_high         = 16'h0e10; // 3.6.
  localparam logic [15:0] xcvr_new_low          = 16'h14b4; // 5.3.
  localparam logic [15:0] xcvr_new_high         = 16'h1036; // 4.15.
  localparam logic [15:0] xcvr_top_coding       = 16'h1f40; // 8.
  localparam logic [15:0] xcvr_top_serial       = 16'h0feb; // 4.075.

  // Number of whole core cycles the fixed pipeline holds a word.
  localparam int fixed_pipe_cycles = 6;

  // Measurement window in core cycles.
  localparam logic [15:0] measure_window = 16'd1024;

  typedef enum logic [1:0] {
    family_small, family_autorate, family_big, family_new
  } family_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } word_t;

endpackage : tx_latency_pkg

/* hdl/tx_path_latency.sv */
// Transmit path: fixed pipeline, delay measurement and slip compensation,
// with an AHB-Lite register slave. Assumes one bus master and one slave.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module tx_path_latency #(
  parameter tx_latency_pkg::family_t family = tx_latency_pkg::family_big,
  parameter bit                      low_rate   = 1'b0,
  parameter bit                      top_rate   = 1'b0,
  parameter bit                      autorate_negotiation = 1'b1,
  parameter int unsigned             fifo_depth = 8
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [31:0] aux_data,
  input  wire logic        aux_valid,
  input  wire logic [31:0] map_data,
  input  wire logic        map_valid,
  input  wire logic        radio_equipment_side,
  input  wire logic        master_mode,
  input  wire logic        frame_resync,
  input  wire logic [4:0]  rx_aligner_slip,
  input  wire logic        tx_link_clk,
  output logic [31:0]      link_data,
  output logic             link_valid,
  output logic [4:0]       link_slip
);
  // Fixed latency selection, thousandths of a core cycle.
  localparam logic [15:0] fixed_core_tx_latency =
    top_rate ? tx_latency_pkg::lat_top_rate :
    (family == tx_latency_pkg::family_autorate) ?
      (low_rate ?
        (autorate_negotiation ? tx_latency_pkg::lat_low_autorate_on
                              : tx_latency_pkg::lat_low_autorate_off) :
        (autorate_negotiation ? tx_latency_pkg::lat_high_autorate_on
                              : tx_latency_pkg::lat_high_autorate_off))
    : low_rate ? tx_latency_pkg::lat_low_all
    : (family == tx_latency_pkg::family_small) ?
      tx_latency_pkg::lat_high_small : tx_latency_pkg::lat_high_big;

  localparam logic [15:0] transceiver_latency =
    top_rate ? 16'(tx_latency_pkg::xcvr_top_coding
                   + tx_latency_pkg::xcvr_top_serial) :
    (family == tx_latency_pkg::family_small) ? tx_latency_pkg::xcvr_small_fam :
    (family == tx_latency_pkg::family_new) ?
      (low_rate ? tx_latency_pkg::xcvr_new_low : tx_latency_pkg::xcvr_new_high)
    : (low_rate ? tx_latency_pkg::xcvr_big_low
                : tx_latency_pkg::xcvr_big_high);

  localparam int ptr_w = $clog2(fifo_depth);

  // Bus slave.
  logic        phase_q;
  logic        write_q;
  logic [7:0]  addr_q;
  logic        take;
  logic        override_q;
  logic [4:0]  manual_slip_q;
  logic [15:0] divider_q;
  logic [31:0] read_mux;
  logic [7:0]  rd_word;
  logic        hit_slip;
  logic        hit_div;
  logic        wr_slip;
  logic        wr_div;

  // Pipeline and buffer.
  tx_latency_pkg::word_t pipe_q [tx_latency_pkg::fixed_pipe_cycles];
  tx_latency_pkg::word_t entry;
  logic [31:0] mem_q [fifo_depth];
  logic [ptr_w:0] wr_ptr_q;
  logic [ptr_w:0] rd_ptr_q;
  logic [ptr_w:0] level;
  logic        clk_s1_q;
  logic        clk_s2_q;
  logic        clk_s3_q;
  logic        read_edge;
  logic        empty;
  logic        full;

  // Slip and measurement.
  logic [4:0]  tx_slip;
  logic [4:0]  held_rx_slip;
  logic [4:0]  rx_slip_s1_q;
  logic [4:0]  rx_slip_s2_q;
  logic        resync_s1_q;
  logic        resync_s2_q;
  logic [31:0] delay_count;
  logic        delay_valid;
  logic        is_slave;

  assign take      = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hit_slip  = (addr_q == tx_latency_pkg::slip_reg_offset);
  assign hit_div   = (addr_q == tx_latency_pkg::divider_reg_offset);
  assign wr_slip   = phase_q && write_q && hit_slip;
  assign wr_div    = phase_q && write_q && hit_div;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= 1'b0;
      write_q <= 1'b0;
      addr_q  <= 8'h00;
    end else begin
      phase_q <= take;
      write_q <= hwrite;
      addr_q  <= {haddr[7:2], 2'b00};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      override_q    <= tx_latency_pkg::override_reset;
      manual_slip_q <= 5'h00;
      divider_q     <= tx_latency_pkg::divider_reset;
    end else begin
      if (wr_slip) begin
        override_q    <= hwdata[tx_latency_pkg::override_bit];
        manual_slip_q <= hwdata[tx_latency_pkg::tx_slip_lsb +: 5];
      end
      if (wr_div && hwdata[15:0] != 16'h0000)
        divider_q <= hwdata[15:0];
    end
  end

  // Reads decode the address phase so the data stands in the data phase.
  assign rd_word  = {haddr[7:2], 2'b00};
  assign read_mux =
    (rd_word == tx_latency_pkg::slip_reg_offset) ?
      {15'h0000, override_q, 3'h0, tx_slip, 3'h0,
       held_rx_slip} :
    (rd_word == tx_latency_pkg::divider_reg_offset) ? {16'h0000, divider_q} :
    (rd_word == tx_latency_pkg::delay_reg_offset) ?
      {delay_valid, delay_count[30:0]} :
    (rd_word == tx_latency_pkg::fixed_reg_offset) ?
      {transceiver_latency, fixed_core_tx_latency} :
    (rd_word == tx_latency_pkg::config_reg_offset) ?
      {28'h0000000, top_rate, low_rate, autorate_negotiation, is_slave} :
    32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (take && !hwrite)
      hrdata <= read_mux;
  end

  // Aux has priority; both ports enter the same pipeline.
  assign entry = {aux_valid || map_valid,
                  aux_valid ? aux_data : map_data};

  // Fixed core pipeline of constant length.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < tx_latency_pkg::fixed_pipe_cycles; i++)
        pipe_q[i] <= '0;
    end else begin
      pipe_q[0] <= entry;
      for (int i = 1; i < tx_latency_pkg::fixed_pipe_cycles; i++)
        pipe_q[i] <= pipe_q[i-1];
    end
  end

  // Transmit clock sampled; its rising edge drains one word.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_s1_q     <= 1'b0;
      clk_s2_q     <= 1'b0;
      clk_s3_q     <= 1'b0;
      rx_slip_s1_q <= 5'h00;
      rx_slip_s2_q <= 5'h00;
      resync_s1_q  <= 1'b0;
      resync_s2_q  <= 1'b0;
    end else begin
      clk_s1_q     <= tx_link_clk;
      clk_s2_q     <= clk_s1_q;
      clk_s3_q     <= clk_s2_q;
      rx_slip_s1_q <= rx_aligner_slip;
      rx_slip_s2_q <= rx_slip_s1_q;
      resync_s1_q  <= frame_resync;
      resync_s2_q  <= resync_s1_q;
    end
  end

  assign read_edge = clk_s2_q && !clk_s3_q;
  assign level     = wr_ptr_q - rd_ptr_q;
  assign empty     = (level == '0);
  assign full      = (level == (ptr_w+1)'(fifo_depth));

  // Elastic buffer between core writes and transmit-clock reads.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_q   <= '0;
      rd_ptr_q   <= '0;
      link_data  <= 32'h0000_0000;
      link_valid <= 1'b0;
      link_slip  <= 5'h00;
    end else begin
      if (pipe_q[tx_latency_pkg::fixed_pipe_cycles-1].valid && !full) begin
        mem_q[wr_ptr_q[ptr_w-1:0]] <=
          pipe_q[tx_latency_pkg::fixed_pipe_cycles-1].data;
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      link_valid <= read_edge && !empty;
      if (read_edge && !empty) begin
        link_data <= mem_q[rd_ptr_q[ptr_w-1:0]];
        link_slip <= tx_slip;
        rd_ptr_q  <= rd_ptr_q + 1'b1;
      end
    end
  end

  assign is_slave = radio_equipment_side && !master_mode;

  tx_delay_meter u_meter (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .divider      (divider_q),
    .occupancy    (4'(level)),
    .tx_clk_level (clk_s2_q),
    .delay_count  (delay_count),
    .delay_valid  (delay_valid)
  );

  slip_compensator #(.width(5)) u_slip (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .master_mode  (!is_slave),
    .override_en  (override_q),
    .manual_slip  (manual_slip_q),
    .rx_slip      (rx_slip_s2_q),
    .resync       (resync_s2_q),
    .tx_slip      (tx_slip),
    .held_rx_slip (held_rx_slip)
  );

  property p_master_zero;
    @(posedge hclk) disable iff (!hresetn)
      (!is_slave) [*3] |-> (tx_slip == 5'h00);
  endproperty
  a_master_zero: assert property (p_master_zero)
    else $error("slip not zero in master mode");

  property p_override;
    @(posedge hclk) disable iff (!hresetn)
      (is_slave && override_q) ##1 (is_slave && override_q)
        |-> tx_slip == $past(manual_slip_q);
  endproperty
  a_override: assert property (p_override)
    else $error("manual slip not applied");

  property p_pipe_len;
    @(posedge hclk) disable iff (!hresetn)
      entry.valid |-> ##6 pipe_q[5].valid;
  endproperty
  a_pipe_len: assert property (p_pipe_len)
    else $error("fixed pipeline length wrong");

  property p_valid_stays;
    @(posedge hclk) disable iff (!hresetn)
      delay_valid |=> delay_valid;
  endproperty
  a_valid_stays: assert property (p_valid_stays)
    else $error("valid flag dropped");

  property p_hold_rx;
    @(posedge hclk) disable iff (!hresetn)
      !resync_s2_q |=> $stable(held_rx_slip);
  endproperty
  a_hold_rx: assert property (p_hold_rx)
    else $error("rx slip changed without resync");

  property p_aux_entry;
    @(posedge hclk) disable iff (!hresetn)
      aux_valid |=> pipe_q[0].valid && pipe_q[0].data == $past(aux_data);
  endproperty
  a_aux_entry: assert property (p_aux_entry)
    else $error("aux word not taken into pipeline");

  property p_map_entry;
    @(posedge hclk) disable iff (!hresetn)
      (map_valid && !aux_valid) |=>
        pipe_q[0].valid && pipe_q[0].data == $past(map_data);
  endproperty
  a_map_entry: assert property (p_map_entry)
    else $error("mapped word not taken into pipeline");

  property p_drain;
    @(posedge hclk) disable iff (!hresetn)
      link_valid |-> $past(read_edge) && !$past(empty);
  endproperty
  a_drain: assert property (p_drain)
    else $error("word launched without a transmit clock edge");

  property p_link_slip;
    @(posedge hclk) disable iff (!hresetn)
      link_valid |-> link_slip == $past(tx_slip);
  endproperty
  a_link_slip: assert property (p_link_slip)
    else $error("launched word does not carry the applied slip");

  property p_read_slip;
    @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && rd_word == tx_latency_pkg::slip_reg_offset) |=>
        (hrdata[12:8] == $past(tx_slip)) &&
        (hrdata[4:0] == $past(held_rx_slip));
  endproperty
  a_read_slip: assert property (p_read_slip)
    else $error("slip register read data wrong");

  c_drain: cover property (@(posedge hclk) link_valid);
  c_measure: cover property (@(posedge hclk) $rose(delay_valid));
  c_manual: cover property (@(posedge hclk) override_q && is_slave);
  c_resync: cover property (@(posedge hclk) resync_s2_q && is_slave);

endmodule : tx_path_latency

/* test/link_partner_model.sv */
// Far-end model: a free-running transmit clock and capture of launched words.
// Assumes hclk is the core clock of the block and link_valid is a pulse.
`timescale 1ns/100ps
module link_partner_model #(
  parameter real half_ns = 200.0
) (
  input  wire logic        hclk,
  input  wire logic [31:0] link_data,
  input  wire logic        link_valid,
  output logic             tx_link_clk,
  output logic [31:0]      last_word,
  output int               word_cnt
);
  // The transceiver clock runs free with a phase unrelated to hclk.
  initial begin
    tx_link_clk = 1'b0;
    #137;
    forever #(half_ns) tx_link_clk = ~tx_link_clk;
  end

  initial begin
    last_word = 32'h0000_0000;
    word_cnt  = 0;
  end

  always @(posedge hclk) begin
    if (link_valid === 1'b1) begin
      last_word <= link_data;
      word_cnt  <= word_cnt + 1;
    end
  end
endmodule : link_partner_model

/* test/tb.sv */
// Self-checking bench for the transmit-path latency block.
// Assumes the package and design files are compiled before this file.
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  localparam int depth = 8;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, aux_data, map_data, link_data, last_word;
  logic        aux_valid, map_valid, link_valid, tx_link_clk;
  logic        radio_equipment_side, master_mode, frame_resync;
  logic [4:0]  rx_aligner_slip, link_slip;
  logic [31:0] rd;
  int          error_cnt, checks_done, word_cnt, n;

  assign hready = hreadyout;

  tx_path_latency #(.family(tx_latency_pkg::family_big), .low_rate(1'b0),
    .top_rate(1'b0), .autorate_negotiation(1'b1), .fifo_depth(depth)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .aux_data(aux_data), .aux_valid(aux_valid), .map_data(map_data),
    .map_valid(map_valid), .radio_equipment_side(radio_equipment_side),
    .master_mode(master_mode), .frame_resync(frame_resync),
    .rx_aligner_slip(rx_aligner_slip), .tx_link_clk(tx_link_clk),
    .link_data(link_data), .link_valid(link_valid), .link_slip(link_slip));

  link_partner_model partner (
    .hclk(hclk), .link_data(link_data), .link_valid(link_valid),
    .tx_link_clk(tx_link_clk), .last_word(last_word), .word_cnt(word_cnt));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic xfer(input bit w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'b010;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : xfer

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(1'b1, a, d, unused);
    repeat (4) @(posedge hclk);
  endtask : reg_wr

  // Sends one word on the aux or the mapped port and counts core cycles
  // from the sampling edge until the word is launched on the link.
  task automatic send(input bit use_map, input logic [31:0] d);
    @(posedge hclk);
    if (use_map) begin
      map_valid <= 1'b1;
      map_data  <= d;
    end else begin
      aux_valid <= 1'b1;
      aux_data  <= d;
    end
    @(posedge hclk);
    map_valid <= 1'b0;
    aux_valid <= 1'b0;
    n = 1;
    while (link_valid !== 1'b1 && n < 60) begin
      @(posedge hclk);
      #1;
      n++;
    end
    `CHK(link_data, d)
    `CHK(n >= tx_latency_pkg::fixed_pipe_cycles, 1'b1)
    `CHK(n <= tx_latency_pkg::fixed_pipe_cycles + 14, 1'b1)
  endtask : send

  task automatic resync_pulse();
    @(posedge hclk);
    frame_resync <= 1'b1;
    @(posedge hclk);
    frame_resync <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask : resync_pulse

  task automatic conclude();
    $display("Checks made: %0d, mismatches: %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  initial begin
    #(50 * 60000);
    error_cnt++;
    conclude();
  end

  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {aux_valid, map_valid, aux_data, map_data} = '0;
    {master_mode, frame_resync, rx_aligner_slip} = '0;
    radio_equipment_side = 1'b1;
    error_cnt = 0;
    checks_done = 0;
    hresetn = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, tx_latency_pkg::slip_reg_offset, '0, rd);
    `CHK(rd[16], tx_latency_pkg::override_reset)
    xfer(1'b0, tx_latency_pkg::divider_reg_offset, '0, rd);
    `CHK(rd[15:0], tx_latency_pkg::divider_reset)
    xfer(1'b0, tx_latency_pkg::fixed_reg_offset, '0, rd);
    `CHK(rd[15:0], tx_latency_pkg::lat_high_big)
    `CHK(rd[31:16], tx_latency_pkg::xcvr_big_high)
    xfer(1'b0, tx_latency_pkg::config_reg_offset, '0, rd);
    `CHK(rd, 32'h0000_0003)
    xfer(1'b0, 8'h14, '0, rd);
    `CHK(rd, 32'h0000_0000)
    `CHK(hresp, 1'b0)
    // A zero divider is refused; the previous value stays in force.
    reg_wr(tx_latency_pkg::divider_reg_offset, 32'h0000_0004);
    reg_wr(tx_latency_pkg::divider_reg_offset, 32'h0000_0000);
    xfer(1'b0, tx_latency_pkg::divider_reg_offset, '0, rd);
    `CHK(rd[15:0], 16'h0004)
    send(1'b0, 32'ha5a5_0001);
    send(1'b1, 32'h5a5a_0002);
    send(1'b0, 32'hc3c3_0003);
    // The count is polled until its valid flag is up.
    rd = '0;
    for (int i = 0; i < 200 && rd[31] !== 1'b1; i++) begin
      repeat (30) @(posedge hclk);
      xfer(1'b0, tx_latency_pkg::delay_reg_offset, '0, rd);
    end
    `CHK(rd[31], 1'b1)
    `CHK((rd[30:0] / 4) <= depth + 1, 1'b1)
    `CHK(word_cnt, 3)
    `CHK(last_word, 32'hc3c3_0003)
    // Slip compensation on a radio-equipment slave; the first resync
    // calibrates the target, so the sum of both slips stays at 3.
    rx_aligner_slip <= 5'h03;
    resync_pulse();
    xfer(1'b0, tx_latency_pkg::slip_reg_offset, '0, rd);
    `CHK(rd[4:0], 5'h03)
    `CHK(rd[12:8], 5'h00)
    rx_aligner_slip <= 5'h05;
    repeat (8) @(posedge hclk);
    xfer(1'b0, tx_latency_pkg::slip_reg_offset, '0, rd);
    `CHK(rd[4:0], 5'h03)
    `CHK(rd[12:8], 5'h00)
    resync_pulse();
    xfer(1'b0, tx_latency_pkg::slip_reg_offset, '0, rd);
    `CHK(rd[4:0], 5'h05)
    `CHK(rd[12:8], 5'h1e)
    send(1'b0, 32'h0f0f_0004);
    `CHK(link_slip, 5'h1e)
    reg_wr(tx_latency_pkg::slip_reg_offset, 32'h0001_0700);
    xfer(1'b0, tx_latency_pkg::slip_reg_offset, '0, rd);
    `CHK(rd[16], 1'b1)
    `CHK(rd[12:8], 5'h07)
    send(1'b1, 32'hf0f0_0005);
    `CHK(link_slip, 5'h07)
    reg_wr(tx_latency_pkg::slip_reg_offset, 32'h0000_0000);
    xfer(1'b0, tx_latency_pkg::slip_reg_offset, '0, rd);
    `CHK(rd[12:8], 5'h1e)
    master_mode <= 1'b1;
    repeat (8) @(posedge hclk);
    xfer(1'b0, tx_latency_pkg::slip_reg_offset, '0, rd);
    `CHK(rd[12:8], 5'h00)
    send(1'b0, 32'h3c3c_0006);
    `CHK(link_slip, 5'h00)
    xfer(1'b0, tx_latency_pkg::config_reg_offset, '0, rd);
    `CHK(rd, 32'h0000_0002)
    conclude();
  end
endmodule : tb
